// file: rtl/fecl_top.v
// Purpose: 4B/5B encoder and decoder, delimiters, carrier sense and link
//          monitor of a 100 Mbps PHY coding layer, with AXI4-Lite control
// Assumes: Line side gives/takes one 5-bit code group per nibble tick;
//          scrambling and line coding sit outside this block
// Notes:   Nibble tick is every second 50 MHz cycle (25 MHz)
//
// What this block does
// - Each nibble encodes to its fixed code group; decoder inverts it.
// - Idle code group is sent continuously between frames.
// - Start delimiter is J then K, replacing two preamble nibbles.
// - End delimiter is T then R, always paired, R last.
// - Error code group H forces a signaling error on transmit.
// - Listed unused code groups are classified invalid on receive.
// - Link comes up after descrambler lock held for 50 ms.
// - Link drops if no run of 16 idles within a 2 ms window.
// - A transient 10 Mbps start indication never makes a link.
// - Link failure clears link status bits and raises a failure event.
// - Link failure restarts negotiation when negotiation is enabled.
// - Packets go out only with link up, unless override is set and negotiation is off.
// - Negotiation on and link down: send pulse bursts, never data.
// - Received start delimiter pair asserts carrier sense.
// - Received end delimiter pair deasserts carrier sense.
// - Idle without end delimiter drops carrier, pulses receive error.
// - Carrier deassert latency may exceed assert latency.
// - Receive valid only on valid symbols, rising with first preamble.
// - Transmit start replaces two nibbles by J K, then encodes.
// - Invalid code group gives receive error with nibble 0101.
// - Transmit error from MAC sends error code groups instead.
// - Received J K pair becomes two preamble nibbles to the MAC.
`timescale 1ns/1ns
`include "fecl_consts.vh"
`default_nettype none

module fecl_top #(
  parameter integer LOCK_CYCLES = `FECL_LOCK_TIME_US * `FECL_CLK_MHZ,
  parameter integer WIN_CYCLES  = `FECL_IDLE_WIN_US * `FECL_CLK_MHZ
) (
  input  wire        clk_in,
  input  wire        rst_in,
  // AXI4-Lite slave
  input  wire [3:0]  s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output reg         s_axi_awready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output reg         s_axi_wready_out,
  output reg  [1:0]  s_axi_bresp_out,
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  input  wire [3:0]  s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output reg         s_axi_arready_out,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  // MII transmit side
  input  wire        tx_en_in,
  input  wire        tx_er_in,
  input  wire [3:0]  txd_in,
  // MII receive side
  output reg  [3:0]  rxd_out,
  output reg         rx_dv_out,
  output reg         rx_er_out,
  output reg         crs_out,
  // Line side
  output reg  [4:0]  tx_code_out,
  input  wire [4:0]  rx_code_in,
  input  wire        descr_lock_in,
  // Link status and events
  output reg         link_up_out,
  output reg         link_fail_out,
  output reg         an_restart_out,
  output reg         flp_send_out,
  output reg         nib_tick_out
);

  // ----------------------------------------------------------------
  // Code tables
  // ----------------------------------------------------------------
  function [4:0] enc;
    input [3:0] n;
    begin
      case (n)
        4'h0:    enc = 5'h1e;
        4'h1:    enc = 5'h09;
        4'h2:    enc = 5'h14;
        4'h3:    enc = 5'h15;
        4'h4:    enc = 5'h0a;
        4'h5:    enc = 5'h0b;
        4'h6:    enc = 5'h0e;
        4'h7:    enc = 5'h0f;
        4'h8:    enc = 5'h12;
        4'h9:    enc = 5'h13;
        4'ha:    enc = 5'h16;
        4'hb:    enc = 5'h17;
        4'hc:    enc = 5'h1a;
        4'hd:    enc = 5'h1b;
        4'he:    enc = 5'h1c;
        default: enc = 5'h1d;
      endcase
    end
  endfunction

  // Returns {valid, nibble}; anything not a data group is invalid
  function [4:0] dec;
    input [4:0] c;
    begin
      case (c)
        5'h1e:   dec = 5'h10;
        5'h09:   dec = 5'h11;
        5'h14:   dec = 5'h12;
        5'h15:   dec = 5'h13;
        5'h0a:   dec = 5'h14;
        5'h0b:   dec = 5'h15;
        5'h0e:   dec = 5'h16;
        5'h0f:   dec = 5'h17;
        5'h12:   dec = 5'h18;
        5'h13:   dec = 5'h19;
        5'h16:   dec = 5'h1a;
        5'h17:   dec = 5'h1b;
        5'h1a:   dec = 5'h1c;
        5'h1b:   dec = 5'h1d;
        5'h1c:   dec = 5'h1e;
        5'h1d:   dec = 5'h1f;
        default: dec = 5'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Nibble tick divider
  // ----------------------------------------------------------------
  reg nib_en;

  // Half rate enable gives the 25 MHz nibble cadence
  always @(posedge clk_in) begin
    if (rst_in) begin
      nib_en       <= 1'b0;
      nib_tick_out <= 1'b0;
    end else begin
      nib_en       <= ~nib_en;
      nib_tick_out <= ~nib_en;
    end
  end

  // ----------------------------------------------------------------
  // Control register and AXI4-Lite slave
  // ----------------------------------------------------------------
  reg [1:0] ctrl;
  reg [3:0] aw_addr;
  reg       aw_held;
  reg [7:0] w_data;
  reg       w_strb0;
  reg       w_held;
  wire      an_en    = ctrl[`FECL_CTRL_AN_EN];
  wire      override = ctrl[`FECL_CTRL_OVERRIDE];
  wire      aw_take  = s_axi_awvalid_in & s_axi_awready_out;
  wire      w_take   = s_axi_wvalid_in & s_axi_wready_out;

  // Address and data may come in either order; response after both
  always @(posedge clk_in) begin
    if (rst_in) begin
      ctrl              <= `FECL_CTRL_RESET;
      aw_addr           <= 4'h0;
      aw_held           <= 1'b0;
      w_data            <= 8'h00;
      w_strb0           <= 1'b0;
      w_held            <= 1'b0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `FECL_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr           <= s_axi_awaddr_in;
        aw_held           <= 1'b1;
        s_axi_awready_out <= 1'b0;
      end
      if (w_take) begin
        w_data           <= s_axi_wdata_in[7:0];
        w_strb0          <= s_axi_wstrb_in[0];
        w_held           <= 1'b1;
        s_axi_wready_out <= 1'b0;
      end
      if (aw_held && w_held && !s_axi_bvalid_out) begin
        aw_held          <= 1'b0;
        w_held           <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        if (aw_addr == `FECL_OFS_CTRL) begin
          s_axi_bresp_out <= `FECL_RESP_OKAY;
          if (w_strb0)
            ctrl <= w_data[1:0];
        end else if (aw_addr == `FECL_OFS_STATUS) begin
          s_axi_bresp_out <= `FECL_RESP_OKAY; // Read-only, write ignored
        end else begin
          s_axi_bresp_out <= `FECL_RESP_DECERR;
        end
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // Reads answer the cycle after the address is taken
  always @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= `FECL_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rresp_out   <= `FECL_RESP_OKAY;
      if (s_axi_araddr_in == `FECL_OFS_CTRL)
        s_axi_rdata_out <= {30'h0000_0000, ctrl};
      else if (s_axi_araddr_in == `FECL_OFS_STATUS)
        s_axi_rdata_out <= {27'h000_0000, flp_send_out, rx_dv_out,
                            crs_out, link_up_out, link_up_out};
      else begin
        s_axi_rdata_out <= 32'h0000_0000;
        s_axi_rresp_out <= `FECL_RESP_DECERR;
      end
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Link monitor
  // ----------------------------------------------------------------
  reg [31:0] lock_cnt;
  reg [31:0] win_cnt;
  reg [4:0]  idle_run;
  reg        idle_seen;
  wire       rx_idle  = (rx_code_in == `FECL_CG_IDLE);
  wire       win_end  = (win_cnt == WIN_CYCLES - 1);
  // Saturated run still counts, so steady idle holds the link window
  wire       run_done = (idle_run >= `FECL_IDLE_RUN_MIN - 5'h01) & rx_idle;

  // Link rests only on descrambler lock and idle density; no 10 Mbps
  // start indication enters here, so none can bring a link up
  always @(posedge clk_in) begin
    if (rst_in) begin
      lock_cnt       <= 32'h0000_0000;
      win_cnt        <= 32'h0000_0000;
      idle_run       <= 5'h00;
      idle_seen      <= 1'b0;
      link_up_out    <= 1'b0;
      link_fail_out  <= 1'b0;
      an_restart_out <= 1'b0;
    end else begin
      link_fail_out  <= 1'b0;
      an_restart_out <= 1'b0;
      // Continuous lock time; any loss starts the wait again
      if (!descr_lock_in)
        lock_cnt <= 32'h0000_0000;
      else if (lock_cnt != LOCK_CYCLES)
        lock_cnt <= lock_cnt + 32'h0000_0001;
      if (nib_en) begin
        if (!rx_idle)
          idle_run <= 5'h00;
        else if (idle_run != `FECL_IDLE_RUN_MIN)
          idle_run <= idle_run + 5'h01;
      end
      win_cnt <= win_end ? 32'h0000_0000 : win_cnt + 32'h0000_0001;
      if (win_end)
        idle_seen <= 1'b0;
      else if (nib_en && run_done)
        idle_seen <= 1'b1;
      if (!link_up_out) begin
        if (descr_lock_in && lock_cnt == LOCK_CYCLES - 1)
          link_up_out <= 1'b1;
      end else if (win_end && !idle_seen && !(nib_en && run_done)) begin
        link_up_out    <= 1'b0;
        link_fail_out  <= 1'b1;
        an_restart_out <= an_en;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit encoder
  // ----------------------------------------------------------------
  localparam [2:0] TX_IDLE  = 3'd0;
  localparam [2:0] TX_K     = 3'd1;
  localparam [2:0] TX_DATA  = 3'd2;
  localparam [2:0] TX_R     = 3'd3;
  localparam [2:0] TX_BLOCK = 3'd4;

  reg  [2:0] tx_state;
  wire       tx_ok = (link_up_out | override) & ~(an_en & ~link_up_out);

  always @(posedge clk_in) begin
    if (rst_in) begin
      tx_state     <= TX_IDLE;
      tx_code_out  <= `FECL_CG_IDLE;
      flp_send_out <= 1'b0;
    end else begin
      flp_send_out <= an_en & ~link_up_out;
      if (nib_en) begin
        case (tx_state)
          TX_IDLE: begin
            if (tx_en_in && tx_ok) begin
              tx_code_out <= `FECL_CG_J;
              tx_state    <= TX_K;
            end else begin
              tx_code_out <= `FECL_CG_IDLE;
              if (tx_en_in)
                tx_state <= TX_BLOCK;
            end
          end
          TX_K: begin
            tx_code_out <= `FECL_CG_K;
            tx_state    <= TX_DATA; // K always follows J, T comes later
          end
          TX_DATA: begin
            if (!tx_en_in) begin
              tx_code_out <= `FECL_CG_T;
              tx_state    <= TX_R;
            end else if (tx_er_in) begin
              tx_code_out <= `FECL_CG_H;
            end else begin
              tx_code_out <= enc(txd_in);
            end
          end
          TX_R: begin
            tx_code_out <= `FECL_CG_R;
            tx_state    <= TX_IDLE;
          end
          TX_BLOCK: begin
            tx_code_out <= `FECL_CG_IDLE; // Drop frame until enable falls
            if (!tx_en_in)
              tx_state <= TX_IDLE;
          end
          default: begin
            tx_code_out <= `FECL_CG_IDLE;
            tx_state    <= TX_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive decoder
  // ----------------------------------------------------------------
  localparam [1:0] RX_IDLE  = 2'd0;
  localparam [1:0] RX_K     = 2'd1;
  localparam [1:0] RX_FRAME = 2'd2;
  localparam [1:0] RX_R     = 2'd3;

  reg  [1:0] rx_state;
  reg  [4:0] prev_code;
  wire [4:0] dec_prev = dec(prev_code);

  // One group of look-ahead lets a delimiter be seen as a whole pair;
  // carrier therefore rises on K and drops on R, the second group of each pair
  always @(posedge clk_in) begin
    if (rst_in) begin
      rx_state  <= RX_IDLE;
      prev_code <= `FECL_CG_IDLE;
      rxd_out   <= 4'h0;
      rx_dv_out <= 1'b0;
      rx_er_out <= 1'b0;
      crs_out   <= 1'b0;
    end else if (nib_en) begin
      prev_code <= rx_code_in;
      rx_er_out <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          rx_dv_out <= 1'b0;
          rxd_out   <= 4'h0;
          if (prev_code == `FECL_CG_J && rx_code_in == `FECL_CG_K) begin
            crs_out   <= 1'b1;
            rx_dv_out <= 1'b1;
            rxd_out   <= `FECL_NIB_PREAMBLE;
            rx_state  <= RX_K;
          end
        end
        RX_K: begin
          rxd_out  <= `FECL_NIB_PREAMBLE;
          rx_state <= RX_FRAME;
        end
        RX_FRAME: begin
          if (prev_code == `FECL_CG_T && rx_code_in == `FECL_CG_R) begin
            crs_out   <= 1'b0;
            rx_dv_out <= 1'b0;
            rxd_out   <= 4'h0;
            rx_state  <= RX_R;
          end else if (prev_code == `FECL_CG_IDLE) begin
            crs_out   <= 1'b0;
            rx_er_out <= 1'b1;
            rx_dv_out <= 1'b0;
            rxd_out   <= 4'h0;
            rx_state  <= RX_IDLE;
          end else if (dec_prev[4]) begin
            rx_dv_out <= 1'b1;
            rxd_out   <= dec_prev[3:0];
          end else begin
            rx_dv_out <= 1'b0;
            rx_er_out <= 1'b1;
            rxd_out   <= `FECL_NIB_PREAMBLE;
          end
        end
        RX_R: begin
          rx_state <= RX_IDLE; // Swallow the R group
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

endmodule // fecl_top

`default_nettype wire

// file: rtl/fecl_consts.vh
// Purpose: Shared constants for the 100 Mbps 4B/5B codec and link monitor
// Assumes: 50 MHz system clock, nibble rate is half of it
// Notes:   Offsets are byte addresses on the AXI4-Lite register bus
`ifndef FECL_CONSTS_VH
`define FECL_CONSTS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define FECL_OFS_CTRL        4'h0
`define FECL_OFS_STATUS      4'h4
`define FECL_CTRL_AN_EN      0
`define FECL_CTRL_OVERRIDE   1
`define FECL_CTRL_RESET      2'h0
`define FECL_STAT_LINK       0
`define FECL_STAT_LINK_COPY  1
`define FECL_STAT_CRS        2
`define FECL_STAT_RX_DV      3
`define FECL_STAT_FLP        4

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define FECL_RESP_OKAY       2'h0
`define FECL_RESP_DECERR     2'h3

// ----------------------------------------------------------------
// Code groups
// ----------------------------------------------------------------
`define FECL_CG_IDLE         5'h1f
`define FECL_CG_J            5'h18
`define FECL_CG_K            5'h11
`define FECL_CG_T            5'h0d
`define FECL_CG_R            5'h07
`define FECL_CG_H            5'h04
`define FECL_NIB_PREAMBLE    4'h5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FECL_CLK_MHZ         50
`define FECL_LOCK_TIME_US    50000
`define FECL_IDLE_WIN_US     2000
`define FECL_IDLE_RUN_MIN    5'h10

`endif

// file: tb/fecl_chk_monitor.sv
// Purpose: Port-level assertions for the codec and link monitor
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound into fecl_top from the bench top file
`timescale 1ns/1ns
`include "fecl_consts.vh"
`default_nettype none

module fecl_chk #(
  parameter integer LOCK_CYCLES = 200
) (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       descr_lock_in,
  input wire logic [4:0] tx_code_out,
  input wire logic [3:0] rxd_out,
  input wire logic       rx_dv_out,
  input wire logic       rx_er_out,
  input wire logic       crs_out,
  input wire logic       link_up_out,
  input wire logic       link_fail_out,
  input wire logic       an_restart_out,
  input wire logic       flp_send_out,
  input wire logic       nib_tick_out
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  int lock_cnt;

  // Lock run length; saturates so it never wraps
  always @(posedge clk_in) begin
    if (rst_in || !descr_lock_in)
      lock_cnt <= 0;
    else if (lock_cnt < LOCK_CYCLES)
      lock_cnt <= lock_cnt + 1;
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence sq_new(c);
    $changed(tx_code_out) && tx_code_out == c;
  endsequence
  sequence sq_pair(a, b);
    tx_code_out == a ##1 tx_code_out == b;
  endsequence

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_tx_start_pair: assert property (sq_new(`FECL_CG_J) |=>
    sq_pair(`FECL_CG_J, `FECL_CG_K)) else $error("J not followed by K");
  a_tx_end_pair: assert property (sq_new(`FECL_CG_T) |=>
    sq_pair(`FECL_CG_T, `FECL_CG_R) ##2
    (tx_code_out inside {`FECL_CG_IDLE, `FECL_CG_J}))
    else $error("T not followed by R then fill");
  a_tx_nibble_hold: assert property ($changed(tx_code_out) |=>
    $stable(tx_code_out)) else $error("code group held under a nibble");
  a_no_data_flp: assert property (sq_new(`FECL_CG_J) |->
    !flp_send_out) else $error("frame started during pulse bursts");
  a_flp_link_up: assert property ($past(link_up_out) |->
    !flp_send_out) else $error("pulse bursts with link up");
  a_fail_pulse: assert property (link_fail_out |->
    !link_up_out ##1 !link_fail_out) else $error("bad failure pulse");
  a_drop_fail: assert property ($fell(link_up_out) |->
    ##[0:1] link_fail_out) else $error("link drop without event");
  a_restart_fail: assert property (an_restart_out |->
    link_fail_out) else $error("restart without link failure");
  a_link_lock: assert property ($rose(link_up_out) |->
    lock_cnt >= LOCK_CYCLES - 2) else $error("link up before lock time");
  a_dv_in_crs: assert property (rx_dv_out |-> crs_out)
    else $error("receive valid outside carrier");
  a_invalid_nib: assert property (rx_er_out && crs_out |->
    rxd_out == 4'h5 && !rx_dv_out) else $error("bad invalid nibble");
  a_crs_start: assert property ($rose(crs_out) |->
    rx_dv_out && rxd_out == 4'h5) else $error("carrier without preamble");
  // Tick must alternate every clock once reset has gone
  a_tick_alt: assert property (!$past(rst_in) |->
    nib_tick_out != $past(nib_tick_out)) else $error("nibble tick stuck");
endmodule // fecl_chk

`default_nettype wire

// file: tb/fecl_mac.sv
// Purpose: MAC side of the media independent interface
// Assumes: Caller sits on a rising clock edge
// Notes:   Transmit only; receive outputs are watched by the bench
`timescale 1ns/1ns
`default_nettype none

module fecl_mac (
  output var logic       tx_en_out,
  output var logic       tx_er_out,
  output var logic [3:0] txd_out
);
  // Idle until the bench asks for a nibble
  initial begin
    tx_en_out = 1'b0;
    tx_er_out = 1'b0;
    txd_out = 4'h0;
  end

  // Gap timing is kept by the caller, never from carrier
  task put(input logic en, input logic er, input logic [3:0] d);
    tx_en_out <= en;
    tx_er_out <= er;
    txd_out <= d;
  endtask
endmodule // fecl_mac

`default_nettype wire

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the codec and link monitor
// Assumes: Short lock and window counts keep the run brief
// Notes:   Models lag the design outputs by one nibble
`timescale 1ns/1ns
`include "fecl_consts.vh"
`default_nettype none

module tb_top;
  // ------------------------------------------------------------
  // Signals and models
  // ------------------------------------------------------------
  localparam int LOCK = 200;
  localparam int WIN = 200;
  localparam logic [4:0] IDLE = `FECL_CG_IDLE, J = `FECL_CG_J;
  localparam logic [4:0] K = `FECL_CG_K, T = `FECL_CG_T;
  localparam logic [4:0] R = `FECL_CG_R, H = `FECL_CG_H;
  logic clk_in, rst_in, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, tx_en, tx_er, rx_dv, rx_er;
  logic crs, lock, link, fail, anr, flp, tick, e, er, lk, an, ovr, rxchk;
  logic [3:0] awaddr, araddr, txd, rxd, d;
  logic [1:0] bresp, rresp;
  logic [31:0] wdata, rdata;
  logic [4:0] tx_code, rx_code, pg, g, q[$];
  logic [4:0] enc [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
    5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  int fails, checks, ts, fr, ercnt, nfail, nanr;

  fecl_top #(.LOCK_CYCLES(LOCK), .WIN_CYCLES(WIN)) uut (
    .clk_in(clk_in), .rst_in(rst_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .tx_en_in(tx_en), .tx_er_in(tx_er), .txd_in(txd), .rxd_out(rxd),
    .rx_dv_out(rx_dv), .rx_er_out(rx_er), .crs_out(crs),
    .tx_code_out(tx_code), .rx_code_in(rx_code), .descr_lock_in(lock),
    .link_up_out(link), .link_fail_out(fail), .an_restart_out(anr),
    .flp_send_out(flp), .nib_tick_out(tick));

  fecl_mac mac (.tx_en_out(tx_en), .tx_er_out(tx_er), .txd_out(txd));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Event pulses last one clock, so count them at every edge
  always @(posedge clk_in) begin
    nfail += fail;
    nanr += anr;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task axw(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
    bit ha, hw;
    ha = 0;
    hw = 0;
    @(posedge clk_in);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(ha && hw)) begin
      @(posedge clk_in);
      if (awvalid && awready === 1'b1) begin ha = 1; awvalid <= 0; end
      if (wvalid && wready === 1'b1) begin hw = 1; wvalid <= 0; end
    end
    while (bvalid !== 1'b1) @(posedge clk_in);
    bready <= 0;
    chk(bresp, r);
  endtask

  task axr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
    @(posedge clk_in);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge clk_in); while (arready !== 1'b1);
    arvalid <= 0;
    while (rvalid !== 1'b1) @(posedge clk_in);
    rready <= 0;
    chk(rdata, v);
    chk(rresp, r);
  endtask

  // One nibble: model what this tick edge sampled, drive the next
  task step(input logic en, ter, input logic [3:0] nd, input logic [4:0] ng);
    logic [4:0] xt;
    logic [6:0] xr;
    logic [6:0] xo;
    do @(negedge clk_in); while (tick !== 1'b1);
    @(posedge clk_in);
    xt = IDLE;
    case (ts)
      0: if (e) begin
        ts = ((lk | ovr) & !(an & !lk)) ? 1 : 4;
        xt = (ts == 1) ? J : IDLE;
      end
      1: begin ts = 2; xt = K; end
      2: if (e) xt = er ? H : enc[d]; else begin ts = 3; xt = T; end
      3: begin ts = 0; xt = R; end
      default: if (!e) ts = 0;
    endcase
    xr = 7'h00;
    if (fr == 0 && pg == J && g == K) begin fr = 1; xr = 7'h65; end
    else if (fr != 0 && pg == T && g == R) fr = 0;
    else if (fr == 1) begin fr = 2; xr = 7'h65; end
    else if (fr == 2) begin
      xr = 7'h55;
      for (int i = 0; i < 16; i++) if (enc[i] == pg) xr = {3'b110, 4'(i)};
    end
    pg = g;
    mac.put(en, ter, nd);
    rx_code <= ng;
    e = en; er = ter; d = nd; g = ng;
    @(negedge clk_in);
    chk(tx_code, xt);
    xo = {crs, rx_dv, rx_er, (rx_dv | rx_er) ? rxd : 4'h0};
    if (rxchk) chk(xo, xr);
    else ercnt += rx_er;
  endtask

  task frame(input bit wer);
    repeat (2) step(1, 0, 4'h5, IDLE);
    for (int i = 0; i < 20; i++)
      step(1, wer && i == 5, (i < 16) ? 4'(i) : 4'($urandom), IDLE);
    repeat (4) step(0, 0, 4'h0, IDLE);
  endtask

  task rxf(input bit term);
    step(0, 0, 4'h0, J);
    step(0, 0, 4'h0, K);
    foreach (q[i]) step(0, 0, 4'h0, q[i]);
    if (term) begin step(0, 0, 4'h0, T); step(0, 0, 4'h0, R); end
    repeat (4) step(0, 0, 4'h0, IDLE);
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, lock} = 0;
    {awaddr, araddr, wdata, e, er, lk, an, ovr, d} = 0;
    {fails, checks, ts, fr, ercnt, nfail, nanr} = 0;
    rx_code = IDLE; pg = IDLE; g = IDLE; rxchk = 1; rst_in = 1;
    void'($urandom(60827));
    repeat (5) @(posedge clk_in);
    rst_in <= 0;
    @(negedge clk_in);
    chk(tx_code, IDLE);
    chk({link, crs, rx_dv, flp}, 0);
    axr(4'h0, 0, `FECL_RESP_OKAY);
    axw(4'hc, 1, `FECL_RESP_DECERR);
    axw(4'h4, 32'h0000_00ff, `FECL_RESP_OKAY);
    axr(4'h8, 0, `FECL_RESP_DECERR);
    axr(4'h4, 0, `FECL_RESP_OKAY);
    $display("test reset done");
    frame(0);
    $display("test refused done");
    lock <= 1;
    repeat (LOCK - 20) @(posedge clk_in);
    chk(link, 0);
    repeat (40) @(posedge clk_in);
    chk(link, 1);
    lk = 1;
    axr(4'h4, 3, `FECL_RESP_OKAY);
    frame(1);
    $display("test transmit done");
    q = {};
    for (int i = 0; i < 20; i++) q.push_back(enc[(i < 16) ? i : $urandom % 16]);
    rxf(1);
    q = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c, 5'h10,
      5'h19, H, enc[7]};
    rxf(1);
    $display("test receive done");
    // Idle inside a frame: exact nibble left open, so count the pulse
    rxchk = 0;
    q = '{enc[3]};
    rxf(0);
    chk(ercnt, 1);
    chk(crs, 0);
    fr = 0;
    rxchk = 1;
    chk(link, 1);
    $display("test idle in frame done");
    axw(4'h0, 1, `FECL_RESP_OKAY);
    an = 1;
    lock <= 0;
    nfail = 0;
    nanr = 0;
    repeat (WIN + 10) step(0, 0, 4'h0, enc[0]);
    lk = 0;
    chk(link, 0);
    chk(nfail, 1);
    chk(nanr, 1);
    chk(flp, 1);
    axr(4'h4, 32'h0000_0010, `FECL_RESP_OKAY);
    $display("test link drop done");
    // Override only as a diagnostic with the link down
    axw(4'h0, 3, `FECL_RESP_OKAY);
    ovr = 1;
    frame(0);
    axw(4'h0, 2, `FECL_RESP_OKAY);
    an = 0;
    frame(0);
    $display("test override done");
    end_of_test();
  end

  // Whole run is about a thousand cycles; this is ample margin
  initial begin
    #400000;
    fails++;
    end_of_test();
  end
endmodule // tb_top

bind fecl_top fecl_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.clk_in, .rst_in,
  .descr_lock_in, .tx_code_out, .rxd_out, .rx_dv_out, .rx_er_out, .crs_out,
  .link_up_out, .link_fail_out, .an_restart_out, .flp_send_out,
  .nib_tick_out);

`default_nettype wire
